// file: wdrs_pkg.sv
// shared constants for the watchdog and reset supervisor
package wdrs_pkg;

  // ----------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DFLT = TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // reset hold and watchdog periods, in milliseconds
  // ----------------------------------------------------------------
  localparam int RST_HOLD_MS = 200;
  localparam int WD_PERIOD_A_MS = 1000;
  localparam int WD_PERIOD_B_MS = 500;
  localparam int WD_PERIOD_C_MS = 250;
  localparam int TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int RST_HOLD_TICKS = RST_HOLD_MS * TICKS_PER_MS;
  localparam int WD_PERIOD_A_TICKS = WD_PERIOD_A_MS * TICKS_PER_MS;
  localparam int WD_PERIOD_B_TICKS = WD_PERIOD_B_MS * TICKS_PER_MS;
  localparam int WD_PERIOD_C_TICKS = WD_PERIOD_C_MS * TICKS_PER_MS;
  localparam int TICK_CNT_W = 16;

  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  localparam int CTRL_W = 8;
  localparam int CTRL_PROTECT_BIT = 7;
  localparam int CTRL_SEL_HI_BIT = 6;
  localparam int CTRL_SEL_LO_BIT = 5;

  // ----------------------------------------------------------------
  // watchdog period selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] WD_SEL_A = 2'h0;
  localparam logic [1:0] WD_SEL_B = 2'h1;
  localparam logic [1:0] WD_SEL_C = 2'h2;
  localparam logic [1:0] WD_SEL_OFF = 2'h3;

  // reset sequencer states
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } wdrs_state_t;

endpackage

// file: wdrs_wd_if.sv
// link between the supervisor core and its watchdog counter
`timescale 1ns/1ps
`default_nettype none
interface wdrs_wd_if;
  logic tick;
  logic restart;
  logic run;
  logic [1:0] period_sel;
  logic expire;
  logic [15:0] count;

  modport ctrl (output tick, output restart, output run, output period_sel, input expire, input count);
  modport wdog (input tick, input restart, input run, input period_sel, output expire, output count);
endinterface
`default_nettype wire

// file: wdrs_wdog.sv
// watchdog counter: counts timebase ticks up to the selected terminal value
`timescale 1ns/1ps
`default_nettype none
module wdrs_wdog
  import wdrs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link to the supervisor core
  wdrs_wd_if.wdog wd
);

  // ----------------------------------------------------------------
  // terminal value for a period selection
  // ----------------------------------------------------------------
  function automatic logic [TICK_CNT_W-1:0] term_of(input logic [1:0] sel);
    logic [TICK_CNT_W-1:0] t;
    t = TICK_CNT_W'(WD_PERIOD_A_TICKS);
    case (sel)
      WD_SEL_B: t = TICK_CNT_W'(WD_PERIOD_B_TICKS);
      WD_SEL_C: t = TICK_CNT_W'(WD_PERIOD_C_TICKS);
      default: t = TICK_CNT_W'(WD_PERIOD_A_TICKS);
    endcase
    return t;
  endfunction

  logic [TICK_CNT_W-1:0] count;
  logic [TICK_CNT_W-1:0] next_count;
  logic expire;
  logic next_expire;
  logic enabled;

  assign enabled = wd.run && (wd.period_sel != WD_SEL_OFF);

  // next count: idle when off, cleared on restart, one-cycle expiry pulse
  always_comb begin
    next_count = count;
    next_expire = 1'b0;
    if (!enabled || wd.restart) begin
      next_count = '0;
    end else if (wd.tick) begin
      if (count + 1'b1 >= term_of(wd.period_sel)) begin
        next_count = '0;
        next_expire = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  // register counter state
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      count <= next_count;
      expire <= next_expire;
    end
  end

  assign wd.expire = expire;
  assign wd.count = count;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_wd_idle_off: assert property (@(posedge clk) disable iff (srst)
    (wd.period_sel == WD_SEL_OFF) |=> (count == '0) && !expire)
    else $error("watchdog counted while disabled");

  chk_wd_restart_clr: assert property (@(posedge clk) disable iff (srst)
    wd.restart |=> (count == '0) && !expire)
    else $error("watchdog not cleared by restart");

  chk_wd_term_reach: assert property (@(posedge clk) disable iff (srst)
    (enabled && !wd.restart && wd.tick && (count + 1'b1 == term_of(wd.period_sel))) |=> expire)
    else $error("watchdog missed its terminal count");

endmodule
`default_nettype wire

// file: wdrs_top.sv
// watchdog and reset supervisor: power-up, low supply and watchdog reset, second supply monitor
// Function
// - reset output open-drain low while supply low
// - hold reset 200ms after supply recovers
// - watchdog expiry asserts reset when enabled
// - start condition restarts watchdog; host must kick
// - power-up asserts reset, held 200ms
// - fail output low while second input low
// - fail output follows comparator, no delay
// - second monitor independent of reset logic
// - second comparison has no hysteresis
// - protect pin plus bit blocks control writes
// - three periods, selection kept across power
// - two control bits select watchdog period
`timescale 1ns/1ps
`default_nettype none
module wdrs_top
  import wdrs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DFLT
)(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // two-wire bus pins, observed only
  input wire logic scl_in,
  input wire logic sda_in,
  // comparator levels and protect pin
  input wire logic vcc_above_trip,
  input wire logic second_supply_monitor_in,
  input wire logic wp_in,
  // control register access from the serial slave
  input wire logic ctrl_wr_en,
  input wire logic [CTRL_W-1:0] ctrl_wr_data,
  output logic [CTRL_W-1:0] ctrl_rd_data,
  // nonvolatile storage of the control register
  input wire logic [CTRL_W-1:0] nv_ctrl_in,
  output logic nv_store,
  // open-drain system reset
  output logic sys_reset_n_o,
  output logic sys_reset_n_oe,
  // open-drain second supply fail
  output logic second_supply_fail_n_o,
  output logic second_supply_fail_n_oe
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [TICK_CNT_W-1:0] HOLD_LAST = TICK_CNT_W'(RST_HOLD_TICKS - 1);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic scl_s;
  logic sda_s;
  logic vcc_ok_s;
  logic v2_ok_s;
  logic wp_s;
  logic sda_d;

  // two flops on every pin input
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sda_d <= 1'b1;
    end else begin
      sync_a <= {wp_in, second_supply_monitor_in, vcc_above_trip, sda_in, scl_in};
      sync_b <= sync_a;
      sda_d <= sync_b[1];
    end
  end

  assign scl_s = sync_b[0];
  assign sda_s = sync_b[1];
  assign vcc_ok_s = sync_b[2];
  assign v2_ok_s = sync_b[3];
  assign wp_s = sync_b[4];

  // ----------------------------------------------------------------
  // start condition detect
  // ----------------------------------------------------------------
  logic start_seen;

  // sda falling while scl high
  assign start_seen = sda_d && !sda_s && scl_s;

  // ----------------------------------------------------------------
  // timebase divider
  // ----------------------------------------------------------------
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic tick;

  // free-running divider, tick is a one-cycle enable
  always_comb begin
    next_div_cnt = (div_cnt == TICK_LAST) ? 16'h0000 : div_cnt + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  assign tick = (div_cnt == TICK_LAST);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic next_nv_store;
  logic wr_blocked;
  logic [1:0] period_sel;

  assign wr_blocked = wp_s && ctrl[CTRL_PROTECT_BIT];

  // accept a write unless protected; request a nonvolatile store
  always_comb begin
    next_ctrl = ctrl;
    next_nv_store = 1'b0;
    if (ctrl_wr_en && !wr_blocked) begin
      next_ctrl = ctrl_wr_data;
      next_nv_store = 1'b1;
    end
  end

  // reload the stored value at reset so selection survives power cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= nv_ctrl_in;
      nv_store <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      nv_store <= next_nv_store;
    end
  end

  assign ctrl_rd_data = ctrl;
  assign period_sel = {ctrl[CTRL_SEL_HI_BIT], ctrl[CTRL_SEL_LO_BIT]};

  // ----------------------------------------------------------------
  // watchdog counter
  // ----------------------------------------------------------------
  wdrs_wd_if wd_link ();

  assign wd_link.tick = tick;
  assign wd_link.restart = start_seen;
  assign wd_link.period_sel = period_sel;

  wdrs_wdog u_wdog (
    .clk(clk),
    .srst(srst),
    .wd(wd_link.ctrl)
  );

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  wdrs_state_t state;
  wdrs_state_t next_state;
  logic [TICK_CNT_W-1:0] hold_cnt;
  logic [TICK_CNT_W-1:0] next_hold_cnt;
  logic rst_active;
  logic next_rst_active;

  // hold reset while supply low, then for the hold time; watchdog expiry re-enters hold
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_rst_active = rst_active;
    case (state)
      ST_HOLD: begin
        next_rst_active = 1'b1;
        if (!vcc_ok_s) begin
          next_hold_cnt = '0;
        end else if (tick) begin
          if (hold_cnt == HOLD_LAST) begin
            next_hold_cnt = '0;
            next_state = ST_RUN;
            next_rst_active = 1'b0;
          end else begin
            next_hold_cnt = hold_cnt + 1'b1;
          end
        end
      end
      ST_RUN: begin
        next_rst_active = 1'b0;
        if (!vcc_ok_s || wd_link.expire) begin
          next_state = ST_HOLD;
          next_hold_cnt = '0;
          next_rst_active = 1'b1;
        end
      end
      default: begin
        next_state = ST_HOLD;
        next_hold_cnt = '0;
        next_rst_active = 1'b1;
      end
    endcase
  end

  // power-up enters hold with reset asserted
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_HOLD;
      hold_cnt <= '0;
      rst_active <= 1'b1;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      rst_active <= next_rst_active;
    end
  end

  // watchdog runs only while reset is released
  assign wd_link.run = (state == ST_RUN);

  // open-drain reset: drive low while active
  assign sys_reset_n_o = 1'b0;
  assign sys_reset_n_oe = rst_active;

  // ----------------------------------------------------------------
  // second supply monitor, separate path
  // ----------------------------------------------------------------
  // follows the synchronised comparator level, no filter or delay
  assign second_supply_fail_n_o = 1'b0;
  assign second_supply_fail_n_oe = !v2_ok_s;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [TICK_CNT_W-1:0] rel_ticks;

  // ticks of good supply since reset last became active or the supply last went low
  always_ff @(posedge clk) begin
    if (srst || !rst_active || !vcc_ok_s) begin
      rel_ticks <= '0;
    end else if (tick && rel_ticks != '1) begin
      rel_ticks <= rel_ticks + 1'b1;
    end
  end

  chk_low_vcc_reset: assert property (@(posedge clk) disable iff (srst)
    !vcc_ok_s |=> sys_reset_n_oe && !sys_reset_n_o)
    else $error("reset not asserted on low supply");

  chk_hold_time: assert property (@(posedge clk) disable iff (srst)
    $fell(sys_reset_n_oe) |-> ($past(rel_ticks) == HOLD_LAST) && vcc_ok_s)
    else $error("reset released before hold time");

  chk_wd_expiry_reset: assert property (@(posedge clk) disable iff (srst)
    (wd_link.expire && period_sel != WD_SEL_OFF) |=> sys_reset_n_oe [*2])
    else $error("watchdog expiry did not assert reset");

  chk_power_up_hold: assert property (@(posedge clk)
    $fell(srst) |-> sys_reset_n_oe ##1 sys_reset_n_oe)
    else $error("reset not held after power-up");

  chk_v2_follow: assert property (@(posedge clk) disable iff (srst)
    (second_supply_fail_n_oe == !v2_ok_s) && !second_supply_fail_n_o)
    else $error("fail output does not follow comparator");

  // pin to fail output is exactly the two synchroniser flops, nothing more
  chk_v2_no_delay: assert property (@(posedge clk) disable iff (srst)
    (!$past(srst) && !$past(srst, 2)) |-> (second_supply_fail_n_oe == !$past(second_supply_monitor_in, 2)))
    else $error("fail output lagged comparator");

  chk_v2_independent: assert property (@(posedge clk) disable iff (srst)
    ($changed(sys_reset_n_oe) && $stable(v2_ok_s)) |-> $stable(second_supply_fail_n_oe))
    else $error("reset path disturbed fail output");

  chk_wp_reject: assert property (@(posedge clk) disable iff (srst)
    (ctrl_wr_en && wp_s && ctrl[CTRL_PROTECT_BIT]) |=> $stable(ctrl) && !nv_store)
    else $error("protected control write accepted");

  chk_wr_accept: assert property (@(posedge clk) disable iff (srst)
    (ctrl_wr_en && !wr_blocked) |=> (ctrl == $past(ctrl_wr_data)) && nv_store)
    else $error("control write not taken");

  chk_wd_off_no_reset: assert property (@(posedge clk) disable iff (srst)
    (period_sel == WD_SEL_OFF) |=> !wd_link.expire)
    else $error("disabled watchdog expired");

  // watchdog stays cleared while reset is held, so start conditions then do nothing
  chk_wd_idle_hold: assert property (@(posedge clk) disable iff (srst)
    rst_active |=> (wd_link.count == '0) && !wd_link.expire)
    else $error("watchdog counted while reset held");

  // hold counter never runs past its last value
  chk_hold_cnt_bound: assert property (@(posedge clk) disable iff (srst)
    hold_cnt <= HOLD_LAST)
    else $error("reset hold count overran");

endmodule
`default_nettype wire

// file: wdrs_host.sv
// host model on the two-wire bus: start conditions and idle data toggles
`timescale 1ns/1ps
`default_nettype none
module wdrs_host (
  // clock
  input wire logic clk,
  // bus lines, pulled high while released
  output logic scl,
  output logic sda
);
  // both lines released to the pull-up level
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // start condition, data falls with clock high, then a stop
  task automatic kick(output time t);
    @(posedge clk);
    sda <= 1'b0;
    t = $time;
    repeat (3) @(posedge clk);
    scl <= 1'b0;
    repeat (3) @(posedge clk);
    scl <= 1'b1;
    repeat (3) @(posedge clk);
    sda <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // data toggles with clock low only, never a start
  task automatic wiggle(input int n);
    @(posedge clk);
    scl <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge clk);
      sda <= ~sda;
    end
    repeat (2) @(posedge clk);
    sda <= 1'b1;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: tb_wdrs_top.sv
// testbench for the reset supervisor: reset timing, watchdog, protect, second supply
`timescale 1ns/1ps
`default_nettype none
module tb_wdrs_top
  import wdrs_pkg::*;
;
  localparam int TC = 4;
  typedef struct {logic [7:0] v; time lo; time hi; bit rel;} wdrs_note_t;
  logic clk, scl, sda, nv_store, rst_o, rst_oe, fail_o, fail_oe, pr, pf;
  logic srst = 1'b1, vcc_ok = 1'b1, v2_in = 1'b1, wp = 1'b0, wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00, nv_mem = 8'h60, rd_data;
  wdrs_note_t rq[$], fq[$], cq[$];
  int fails = 0, compares = 0;
  bit armed = 0;
  time lr;

  wdrs_top #(.TICK_CYCLES(TC)) i_wdrs_top (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .vcc_above_trip(vcc_ok), .second_supply_monitor_in(v2_in), .wp_in(wp), .ctrl_wr_en(wr_en),
    .ctrl_wr_data(wr_data), .ctrl_rd_data(rd_data), .nv_ctrl_in(nv_mem), .nv_store(nv_store),
    .sys_reset_n_o(rst_o), .sys_reset_n_oe(rst_oe), .second_supply_fail_n_o(fail_o),
    .second_supply_fail_n_oe(fail_oe));
  wdrs_host i_wdrs_host (.clk(clk), .scl(scl), .sda(sda));

  // clock and nonvolatile store model
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (nv_store === 1'b1) nv_mem <= rd_data;

  task automatic summarize();
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string nm);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %0t: %s got %h want %h", $time, nm, got, exp);
    end
  endtask

  // oldest note against an observed event, value and time window
  task automatic chk(ref wdrs_note_t q[$], input logic [7:0] got, input time base, input string nm);
    wdrs_note_t n;
    time te;
    te = $time - 25;
    compares++;
    if (q.size() == 0) begin
      fails++;
      $display("unexpected %0t: %s event with none pending", $time, nm);
    end else begin
      n = q.pop_front();
      if (!n.rel) base = 0;
      if (got !== n.v || te < base + n.lo || te > base + n.hi) begin
        fails++;
        $display("unexpected %0t: %s got %h want %h in %0t..%0t", $time, nm, got, n.v, base + n.lo, base + n.hi);
      end
    end
  endtask

  // output watcher
  always @(negedge clk) begin
    if (armed) begin
      if (rst_oe !== pr) begin
        chk(rq, {7'h00, rst_oe}, lr, "reset");
        lr = $time - 25;
        pr = rst_oe;
      end
      if (fail_oe !== pf) begin
        chk(fq, {7'h00, fail_oe}, 0, "fail");
        pf = fail_oe;
      end
      if (nv_store === 1'b1) chk(cq, rd_data, 0, "store");
      cmp({6'h00, rst_o, fail_o}, 8'h00, "pin data");
    end
  end

  task automatic wr(input logic [7:0] d, input bit ok);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_data <= d;
    if (ok) cq.push_back('{d, $time + 50, $time + 50, 1'b0});
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    if (armed) rq.push_back('{8'h01, $time + 50, $time + 50, 1'b0});
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rq.push_back('{8'h00, $time + 199 * TC * 50, $time + (200 * TC + 4) * 50, 1'b0});
  endtask

  task automatic wait_rst(input logic v, input int lim);
    int k;
    k = 0;
    while (rst_oe !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    cmp(rst_oe, v, "reset wait");
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("unexpected %0t: run did not finish", $time);
    summarize();
  end

  // main sequence
  initial begin
    time tk;
    logic [7:0] d;
    int term;
    void'($urandom(32'h62C2DCB4));
    do_reset();
    fq.push_back('{8'h00, $time + 50, $time + 150, 1'b0});
    @(negedge clk);
    pr = rst_oe;
    pf = fail_oe;
    lr = $time - 25;
    armed = 1;
    cmp(rst_oe, 1'b1, "power-up");
    cmp(rd_data, 8'h60, "nv load");
    wait_rst(1'b0, 210 * TC);
    repeat (1100 * TC) @(posedge clk);
    cmp(rst_oe, 1'b0, "watchdog off");
    $display("test power-up done at %0t", $time);
    for (int s = 0; s < 3; s++) begin
      term = s == 0 ? WD_PERIOD_A_TICKS : s == 1 ? WD_PERIOD_B_TICKS : WD_PERIOD_C_TICKS;
      d = {1'b0, 2'(s), 5'($urandom)};
      wr(d, 1'b1);
      for (int k = 0; k < 3; k++) begin
        if (k > 0) repeat (term * TC / 4 + $urandom % (term * TC / 4)) @(posedge clk);
        i_wdrs_host.kick(tk);
      end
      rq.push_back('{8'h01, tk + ((term - 1) * TC + 2) * 50, tk + (term * TC + 6) * 50, 1'b0});
      rq.push_back('{8'h00, 199 * TC * 50, (200 * TC + 4) * 50, 1'b1});
      i_wdrs_host.wiggle(3 + $urandom % 4);
      wait_rst(1'b1, term * TC + 50);
      wait_rst(1'b0, 210 * TC);
      $display("test watchdog period %0d done at %0t", s, $time);
    end
    wp <= 1'b1;
    repeat (3) @(posedge clk);
    wr(8'hE0, 1'b1);
    wr(8'h00, 1'b0);
    repeat (4) @(posedge clk);
    cmp(rd_data, 8'hE0, "locked");
    $display("test protect done at %0t", $time);
    fork
      begin
        @(posedge clk);
        vcc_ok <= 1'b0;
        rq.push_back('{8'h01, $time + 150, $time + 150, 1'b0});
        repeat (20 + $urandom % 40) @(posedge clk);
        vcc_ok <= 1'b1;
        rq.push_back('{8'h00, $time + 199 * TC * 50, $time + (200 * TC + 6) * 50, 1'b0});
      end
      for (int i = 0; i < 7; i++) begin
        repeat (3 + $urandom % 8) @(posedge clk);
        v2_in <= i[0];
        fq.push_back('{{7'h00, ~i[0]}, $time + 100, $time + 100, 1'b0});
      end
    join
    wait_rst(1'b0, 210 * TC);
    $display("test supplies done at %0t", $time);
    do_reset();
    @(negedge clk);
    cmp(rd_data, 8'hE0, "kept");
    wait_rst(1'b0, 210 * TC);
    wr(8'h20, 1'b0);
    repeat (4) @(posedge clk);
    cmp(rd_data, 8'hE0, "still locked");
    cmp(8'(rq.size() + fq.size() + cq.size()), 8'h00, "pending");
    $display("test power cycle done at %0t", $time);
    summarize();
  end
endmodule
`default_nettype wire
